// *** e1lac_top.sv ***
// Functional notes
// - First common control bit 7 set enters framer loopback.
// - Framer loopback feeds transmit data to receiver; line transmit stays normal.
// - Framer loopback drives recovered clock output from transmit clock input.
// - Counter update every second, or every 500 frames when bit 7 set.
// - Bit 6 selects bipolar violations (0) or code violations (1).
// - Auto AIS sends AIS on frame loss, received AIS or carrier loss.
// - Auto RAI on those conditions, or CRC4 multiframe missing 128ms after FAS.
// - Auto RAI becomes constant if CRC4 multiframe sync missing 400ms.
// - Bit 3 forces receive serial output high during frame alignment loss.
// - Bit 2 switches formatter to recovered clock when transmit clock stops.
// - Carrier loss after 255 zeros, or 2048 zeros when bit 1 set.
// - Bit 0 forces recovered clock for formatter, ignoring transmit clock pin.
// - Remote loopback retransmits received line data; framer still receives normally.
// - Loopback register bit 6 enables local loopback.
// - Line AIS bit sends unframed all ones at master clock rate.
// - Bits 4..0 pick transmit channel copied into channel monitor register.
// - Local loopback keeps transmitting and replaces received data with transmitted data.
`timescale 1ns/1ps
`include "e1lac_defines.svh"
module e1lac_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic transmit_clock_in,
   input wire logic recovered_clock_in,
   input wire logic master_clock_in,
   input wire logic line_rx_pos,
   input wire logic line_rx_neg,
   input wire e1lac_pkg::e1lac_pair_t fmt_tx,
   input wire logic fmt_tx_nrz,
   input wire logic fmt_tx_frame_start,
   input wire e1lac_pkg::e1lac_rx_status_t rx_status,
   input wire logic rx_ser_in,
   output logic line_tx_pos,
   output logic line_tx_neg,
   output e1lac_pkg::e1lac_pair_t framer_rx,
   output logic rx_clock_out,
   output logic rx_serial_out,
   output logic tx_ais_force,
   output logic tx_rai_force,
   output logic rai_constant,
   output logic carrier_loss,
   output logic tx_clock_loss,
   output logic tx_clk_use_recovered,
   output logic counter_update,
   output logic violation_count_select,
   output logic [7:0] tx_channel_monitor_reg
);
   import e1lac_pkg::*;

   function automatic logic rising(input logic cur, input logic prev);
      rising = cur & ~prev;
   endfunction

   // Pins: 0 tx clock, 1 recovered clock, 2 master clock, 3 rx pos, 4 rx neg.
   logic [4:0] pin_in;
   logic [4:0] sync1_r, sync2_r, sync3_r;
   assign pin_in = {line_rx_neg, line_rx_pos, master_clock_in, recovered_clock_in, transmit_clock_in};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sync
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
               sync3_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= pin_in[gi];
               sync2_r[gi] <= sync1_r[gi];
               sync3_r[gi] <= sync2_r[gi];
            end
         end
      end
   endgenerate

   logic txclk_s, rclk_s, mclk_s;
   logic txclk_rise, rclk_rise, mclk_rise;
   e1lac_pair_t line_rx_s;
   assign txclk_s = sync2_r[0];
   assign rclk_s = sync2_r[1];
   assign mclk_s = sync2_r[2];
   assign line_rx_s = {sync2_r[3], sync2_r[4]};
   assign txclk_rise = rising(sync2_r[0], sync3_r[0]);
   assign rclk_rise = rising(sync2_r[1], sync3_r[1]);
   assign mclk_rise = rising(sync2_r[2], sync3_r[2]);

   // Register port.
   logic [7:0] ctrl1_r, ctrl1_nxt;
   e1lac_ctrl2_t ctrl2_r, ctrl2_nxt;
   e1lac_ctrl3_t ctrl3_r, ctrl3_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic floop, crc4_en;

   assign floop = ctrl1_r[`E1LAC_FLOOP_BIT];
   assign crc4_en = ctrl1_r[`E1LAC_RCRC4_BIT];

   always_comb begin
      ctrl1_nxt = ctrl1_r;
      ctrl2_nxt = ctrl2_r;
      ctrl3_nxt = ctrl3_r;
      rdata_nxt = rdata_r;
      if (reg_wr) begin
         unique case (reg_addr)
            `E1LAC_ADDR_CTRL1: ctrl1_nxt = reg_wdata;
            `E1LAC_ADDR_CTRL2: ctrl2_nxt = e1lac_ctrl2_t'(reg_wdata);
            `E1LAC_ADDR_CTRL3: ctrl3_nxt = e1lac_ctrl3_t'(reg_wdata);
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `E1LAC_ADDR_CTRL1: rdata_nxt = ctrl1_r;
            `E1LAC_ADDR_CTRL2: rdata_nxt = ctrl2_r;
            `E1LAC_ADDR_CTRL3: rdata_nxt = ctrl3_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl1_r <= `E1LAC_CTRL1_RST;
         ctrl2_r <= `E1LAC_CTRL2_RST;
         ctrl3_r <= `E1LAC_CTRL3_RST;
         rdata_r <= 8'h00;
      end else begin
         ctrl1_r <= ctrl1_nxt;
         ctrl2_r <= ctrl2_nxt;
         ctrl3_r <= ctrl3_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Supervision counters: transmit clock loss, carrier zeros, CRC4 search, update period.
   logic [6:0] clk_idle_r, clk_idle_nxt;
   logic [11:0] zeros_r, zeros_nxt;
   logic [11:0] crc_wait_r, crc_wait_nxt;
   logic [12:0] upd_cnt_r, upd_cnt_nxt;
   logic txloss_r, txloss_nxt, cl_r, cl_nxt, upd_r, upd_nxt;
   logic [11:0] cl_limit;
   logic [12:0] upd_limit;

   always_comb begin
      clk_idle_nxt = clk_idle_r;
      txloss_nxt = txloss_r;
      if (txclk_rise) begin
         clk_idle_nxt = 7'h00;
         txloss_nxt = 1'b0;
      end else if (clk_idle_r == 7'(`E1LAC_TXCLK_LOSS_CYC - 1)) begin
         txloss_nxt = 1'b1;
      end else begin
         clk_idle_nxt = clk_idle_r + 7'h01;
      end
      cl_limit = ctrl2_r.carrier_loss_criteria ? 12'(`E1LAC_CL_ZEROS_ALT) : 12'(`E1LAC_CL_ZEROS_STD);
      zeros_nxt = zeros_r;
      cl_nxt = cl_r;
      if (rclk_rise) begin
         if (line_rx_s.pos | line_rx_s.neg) begin
            zeros_nxt = 12'h000;
            cl_nxt = 1'b0;
         end else if (zeros_r + 12'h001 >= cl_limit) begin
            zeros_nxt = cl_limit;
            cl_nxt = 1'b1;
         end else begin
            zeros_nxt = zeros_r + 12'h001;
         end
      end
      crc_wait_nxt = crc_wait_r;
      if (!crc4_en || !rx_status.fas_sync || rx_status.crc4_mf_sync) begin
         crc_wait_nxt = 12'h000;
      end else if (rx_status.frame_tick && crc_wait_r != 12'(`E1LAC_CRC4_CONST_FRM)) begin
         crc_wait_nxt = crc_wait_r + 12'h001;
      end
      upd_limit = ctrl2_r.counter_update_select ? 13'(`E1LAC_UPD_FAST_FRM) : 13'(`E1LAC_UPD_SLOW_FRM);
      upd_cnt_nxt = upd_cnt_r;
      upd_nxt = 1'b0;
      if (rx_status.frame_tick) begin
         if (upd_cnt_r + 13'h0001 >= upd_limit) begin
            upd_cnt_nxt = 13'h0000;
            upd_nxt = 1'b1;
         end else begin
            upd_cnt_nxt = upd_cnt_r + 13'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clk_idle_r <= 7'h00;
         txloss_r <= 1'b0;
         zeros_r <= 12'h000;
         cl_r <= 1'b0;
         crc_wait_r <= 12'h000;
         upd_cnt_r <= 13'h0000;
         upd_r <= 1'b0;
      end else begin
         clk_idle_r <= clk_idle_nxt;
         txloss_r <= txloss_nxt;
         zeros_r <= zeros_nxt;
         cl_r <= cl_nxt;
         crc_wait_r <= crc_wait_nxt;
         upd_cnt_r <= upd_cnt_nxt;
         upd_r <= upd_nxt;
      end
   end

   // Data paths and alarm outputs.
   e1lac_pair_t ltx_r, ltx_nxt, frx_r, frx_nxt;
   logic mpol_r, mpol_nxt;
   logic rclko_r, rclko_nxt, rxser_r, rxser_nxt, ais_r, ais_nxt, rai_r, rai_nxt;
   logic raic_r, raic_nxt, usercv_r, usercv_nxt, vsel_r, vsel_nxt;
   logic alarm_any;

   always_comb begin
      alarm_any = rx_status.frame_loss | rx_status.ais_rx | cl_r;
      mpol_nxt = mclk_rise ? ~mpol_r : mpol_r;
      // AMI all ones on master clock.
      if (ctrl3_r.line_all_ones_enable) begin
         // The new polarity is used from the first high cycle so that one mark never splits across both rails.
         ltx_nxt = {mclk_s & mpol_nxt, mclk_s & ~mpol_nxt};
      end else if (ctrl3_r.remote_loop_enable) begin
         ltx_nxt = line_rx_s;
      end else begin
         ltx_nxt = fmt_tx;
      end
      if (floop) begin
         frx_nxt = fmt_tx;
      end else if (ctrl3_r.local_loop_enable) begin
         frx_nxt = ltx_r;
      end else begin
         frx_nxt = line_rx_s;
      end
      rclko_nxt = floop ? txclk_s : rclk_s;
      rxser_nxt = (ctrl2_r.rx_serial_force_control & rx_status.frame_loss) | rx_ser_in;
      ais_nxt = ctrl2_r.auto_all_ones_alarm_enable & alarm_any;
      raic_nxt = ctrl2_r.auto_remote_alarm_enable && crc_wait_r == 12'(`E1LAC_CRC4_CONST_FRM);
      rai_nxt = ctrl2_r.auto_remote_alarm_enable
                && (alarm_any || crc_wait_r >= 12'(`E1LAC_CRC4_RAI_FRM));
      usercv_nxt = ctrl2_r.tx_clock_source_select | (ctrl2_r.tx_clock_loss_mux & txloss_r);
      vsel_nxt = ctrl2_r.violation_count_select;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ltx_r <= '0;
         frx_r <= '0;
         mpol_r <= 1'b0;
         rclko_r <= 1'b0;
         rxser_r <= 1'b0;
         ais_r <= 1'b0;
         rai_r <= 1'b0;
         raic_r <= 1'b0;
         usercv_r <= 1'b0;
         vsel_r <= 1'b0;
      end else begin
         ltx_r <= ltx_nxt;
         frx_r <= frx_nxt;
         mpol_r <= mpol_nxt;
         rclko_r <= rclko_nxt;
         rxser_r <= rxser_nxt;
         ais_r <= ais_nxt;
         rai_r <= rai_nxt;
         raic_r <= raic_nxt;
         usercv_r <= usercv_nxt;
         vsel_r <= vsel_nxt;
      end
   end

   // The monitor samples on the clock the formatter actually uses.
   logic tx_bit_stb;
   assign tx_bit_stb = usercv_r ? rclk_rise : txclk_rise;

   e1lac_chan_monitor u_mon (
      .ref_clk(ref_clk),
      .rst(rst),
      .bit_stb(tx_bit_stb),
      .bit_in(fmt_tx_nrz),
      .frame_start(fmt_tx_frame_start),
      .chan(ctrl3_r.tx_monitor_channel),
      .mon_byte(tx_channel_monitor_reg)
   );

   assign reg_rdata = rdata_r;
   assign line_tx_pos = ltx_r.pos;
   assign line_tx_neg = ltx_r.neg;
   assign framer_rx = frx_r;
   assign rx_clock_out = rclko_r;
   assign rx_serial_out = rxser_r;
   assign tx_ais_force = ais_r;
   assign tx_rai_force = rai_r;
   assign rai_constant = raic_r;
   assign carrier_loss = cl_r;
   assign tx_clock_loss = txloss_r;
   assign tx_clk_use_recovered = usercv_r;
   assign counter_update = upd_r;
   assign violation_count_select = vsel_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_floop_data;
      floop |=> framer_rx == $past(fmt_tx);
   endproperty
   a_floop_data: assert property (p_floop_data) else $error("framer loop data not routed");
   property p_floop_clk;
      floop |=> rx_clock_out == $past(txclk_s);
   endproperty
   a_floop_clk: assert property (p_floop_clk) else $error("clock output not from tx clock");
   property p_auto_ais;
      (ctrl2_r.auto_all_ones_alarm_enable && rx_status.frame_loss) |=> tx_ais_force;
   endproperty
   a_auto_ais: assert property (p_auto_ais) else $error("auto AIS missing");
   property p_auto_rai;
      (ctrl2_r.auto_remote_alarm_enable && rx_status.ais_rx) |=> tx_rai_force;
   endproperty
   a_auto_rai: assert property (p_auto_rai) else $error("auto RAI missing");
   property p_rai_const;
      (ctrl2_r.auto_remote_alarm_enable && crc_wait_r == 12'(`E1LAC_CRC4_CONST_FRM)) |=> rai_constant && tx_rai_force;
   endproperty
   a_rai_const: assert property (p_rai_const) else $error("constant RAI missing");
   property p_rx_serial_out;
      (ctrl2_r.rx_serial_force_control && rx_status.frame_loss) |=> rx_serial_out;
   endproperty
   a_rx_serial_out: assert property (p_rx_serial_out) else $error("serial output not forced");
   property p_clk_fallback;
      (ctrl2_r.tx_clock_loss_mux && tx_clock_loss) |=> tx_clk_use_recovered;
   endproperty
   a_clk_fallback: assert property (p_clk_fallback) else $error("no fallback clock");
   property p_clk_loss;
      (!txclk_rise)[*8] ##1 (clk_idle_r == 7'(`E1LAC_TXCLK_LOSS_CYC - 1) && !txclk_rise) |=> tx_clock_loss;
   endproperty
   a_clk_loss: assert property (p_clk_loss) else $error("clock loss not flagged");
   property p_cl_std;
      (!ctrl2_r.carrier_loss_criteria && zeros_r < 12'(`E1LAC_CL_ZEROS_STD)) |-> !carrier_loss;
   endproperty
   a_cl_std: assert property (p_cl_std) else $error("carrier loss too early");
   property p_remote;
      (ctrl3_r.remote_loop_enable && !ctrl3_r.line_all_ones_enable) |=> line_tx_pos == $past(line_rx_s.pos);
   endproperty
   a_remote: assert property (p_remote) else $error("remote loop data wrong");
   property p_line_ais;
      ctrl3_r.line_all_ones_enable |=> !(line_tx_pos && line_tx_neg);
   endproperty
   a_line_ais: assert property (p_line_ais) else $error("AIS drives both rails");
   property p_upd_pulse;
      counter_update |=> !counter_update;
   endproperty
   a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse too long");

   c_floop: cover property (floop && rx_clock_out);
   c_fallback: cover property (tx_clock_loss && tx_clk_use_recovered);
   c_rai_const: cover property (rai_constant);
   c_update: cover property (counter_update);
endmodule // e1lac_top

// *** e1lac_defines.svh ***
`ifndef E1LAC_DEFINES_SVH
`define E1LAC_DEFINES_SVH

`define E1LAC_ADDR_CTRL1 8'h12
`define E1LAC_ADDR_CTRL2 8'h13
`define E1LAC_ADDR_CTRL3 8'h14

`define E1LAC_CTRL1_RST 8'h00
`define E1LAC_CTRL2_RST 8'h00
`define E1LAC_CTRL3_RST 8'h00

`define E1LAC_FLOOP_BIT 7
`define E1LAC_RCRC4_BIT 0

`define E1LAC_REF_CLK_NS 10
`define E1LAC_FRAME_NS 125000
`define E1LAC_TXCLK_LOSS_NS 1000
`define E1LAC_TXCLK_LOSS_CYC (`E1LAC_TXCLK_LOSS_NS / `E1LAC_REF_CLK_NS)
`define E1LAC_UPD_FAST_US 62500
`define E1LAC_UPD_SLOW_US 1000000
`define E1LAC_UPD_FAST_FRM ((`E1LAC_UPD_FAST_US * 1000) / `E1LAC_FRAME_NS)
`define E1LAC_UPD_SLOW_FRM ((`E1LAC_UPD_SLOW_US * 1000) / `E1LAC_FRAME_NS)
`define E1LAC_CRC4_RAI_MS 128
`define E1LAC_CRC4_CONST_MS 400
`define E1LAC_CRC4_RAI_FRM ((`E1LAC_CRC4_RAI_MS * 1000000) / `E1LAC_FRAME_NS)
`define E1LAC_CRC4_CONST_FRM ((`E1LAC_CRC4_CONST_MS * 1000000) / `E1LAC_FRAME_NS)
`define E1LAC_CL_ZEROS_STD 255
`define E1LAC_CL_ZEROS_ALT 2048

`endif

// *** e1lac_pkg.sv ***
package e1lac_pkg;

   typedef struct packed {
      logic counter_update_select;
      logic violation_count_select;
      logic auto_all_ones_alarm_enable;
      logic auto_remote_alarm_enable;
      logic rx_serial_force_control;
      logic tx_clock_loss_mux;
      logic carrier_loss_criteria;
      logic tx_clock_source_select;
   } e1lac_ctrl2_t;

   typedef struct packed {
      logic remote_loop_enable;
      logic local_loop_enable;
      logic line_all_ones_enable;
      logic [4:0] tx_monitor_channel;
   } e1lac_ctrl3_t;

   typedef struct packed {
      logic frame_loss;
      logic ais_rx;
      logic fas_sync;
      logic crc4_mf_sync;
      logic frame_tick;
   } e1lac_rx_status_t;

   typedef struct packed {
      logic pos;
      logic neg;
   } e1lac_pair_t;

endpackage

// *** e1lac_chan_monitor.sv ***
`timescale 1ns/1ps
module e1lac_chan_monitor (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic bit_stb,
   input wire logic bit_in,
   input wire logic frame_start,
   input wire logic [4:0] chan,
   output logic [7:0] mon_byte
);
   logic [7:0] bit_cnt_r, bit_cnt_nxt;
   logic [6:0] shift_r, shift_nxt;
   logic [7:0] byte_r, byte_nxt;
   logic [7:0] pos;

   assign mon_byte = byte_r;

   always_comb begin
      pos = frame_start ? 8'h00 : bit_cnt_r;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt = shift_r;
      byte_nxt = byte_r;
      if (bit_stb) begin
         bit_cnt_nxt = pos + 8'h01;
         shift_nxt = {shift_r[5:0], bit_in};
         if (pos[7:3] == chan && pos[2:0] == 3'h7) begin
            byte_nxt = {shift_r, bit_in};
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bit_cnt_r <= 8'h00;
         shift_r <= 7'h00;
         byte_r <= 8'h00;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
         shift_r <= shift_nxt;
         byte_r <= byte_nxt;
      end
   end
endmodule // e1lac_chan_monitor

// *** e1lac_line_model.sv ***
`timescale 1ns/1ps
module e1lac_line_model (
   input wire logic ref_clk,
   input wire logic txclk_run,
   input wire logic rx_zeros,
   output logic transmit_clock_in,
   output logic recovered_clock_in,
   output logic master_clock_in,
   output logic line_rx_pos,
   output logic line_rx_neg
);
   logic t_r;
   logic [1:0] c3_r;
   logic [2:0] c5_r;
   logic pol_r;
   initial begin
      t_r = 1'h0;
      c3_r = 2'h0;
      c5_r = 3'h0;
      pol_r = 1'h0;
      transmit_clock_in = 1'h0;
      recovered_clock_in = 1'h0;
      master_clock_in = 1'h0;
      line_rx_pos = 1'h0;
      line_rx_neg = 1'h0;
   end
   // Clocks are divided from the bench clock so that every count in the bench is deterministic.
   // Transmit clock period is 4 cycles, recovered 6, master 10; a stopped transmit clock stands still.
   always @(posedge ref_clk) begin
      t_r <= ~t_r;
      c3_r <= (c3_r == 2'h2) ? 2'h0 : c3_r + 2'h1;
      c5_r <= (c5_r == 3'h4) ? 3'h0 : c5_r + 3'h1;
      if (txclk_run && t_r) begin
         transmit_clock_in <= ~transmit_clock_in;
      end
      if (c3_r == 2'h2) begin
         recovered_clock_in <= ~recovered_clock_in;
         if (!recovered_clock_in) begin
            // A zero leaves both rails low; marks alternate polarity as on a real line.
            line_rx_pos <= !rx_zeros && !pol_r;
            line_rx_neg <= !rx_zeros && pol_r;
            pol_r <= pol_r ^ !rx_zeros;
         end
      end
      if (c5_r == 3'h4) begin
         master_clock_in <= ~master_clock_in;
      end
   end
endmodule // e1lac_line_model

// *** tb_e1_loopback_alarm_clock_control.sv ***
`timescale 1ns/1ps
module tb_e1_loopback_alarm_clock_control;
   import e1lac_pkg::*;
   typedef struct packed {
      logic [7:0] c1;
      logic [7:0] c2;
      logic [7:0] c3;
      e1lac_pair_t fmt;
      e1lac_rx_status_t st;
      logic ser;
      logic zer;
      logic [1:0] etx;
      logic [1:0] efrx;
      logic cfrx;
      logic eser;
      logic [1:0] ealm;
      logic evs;
      logic eusr;
   } e1lac_row_t;
   e1lac_row_t rows [12] = '{
      '{8'h00, 8'h00, 8'h00, 2'h2, 5'h00, 1'h0, 1'h0, 2'h2, 2'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0},
      '{8'h80, 8'h00, 8'h00, 2'h1, 5'h00, 1'h0, 1'h0, 2'h1, 2'h1, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0},
      '{8'h00, 8'h00, 8'h40, 2'h2, 5'h00, 1'h0, 1'h0, 2'h2, 2'h2, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0},
      '{8'h00, 8'h00, 8'h80, 2'h3, 5'h00, 1'h0, 1'h1, 2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0},
      '{8'h00, 8'h08, 8'h00, 2'h0, 5'h10, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h1, 2'h0, 1'h0, 1'h0},
      '{8'h00, 8'h00, 8'h00, 2'h0, 5'h10, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0},
      '{8'h00, 8'h20, 8'h00, 2'h0, 5'h10, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h2, 1'h0, 1'h0},
      '{8'h00, 8'h20, 8'h00, 2'h0, 5'h08, 1'h1, 1'h0, 2'h0, 2'h0, 1'h0, 1'h1, 2'h2, 1'h0, 1'h0},
      '{8'h00, 8'h10, 8'h00, 2'h0, 5'h08, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0},
      '{8'h00, 8'h30, 8'h00, 2'h0, 5'h04, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0},
      '{8'h00, 8'h40, 8'h00, 2'h0, 5'h00, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0},
      '{8'h00, 8'h01, 8'h00, 2'h0, 5'h00, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h1}};
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [7:0] reg_rdata;
   logic txclk_run = 1'h1;
   logic rx_zeros = 1'h0;
   logic nrz = 1'h0;
   logic txc, rclk, mclk, rxp, rxn;
   e1lac_pair_t fmt = 2'h0;
   e1lac_rx_status_t st = 5'h00;
   logic ser = 1'h0;
   e1lac_pair_t frx;
   logic txp, txn, rxco, rso, ais, rai, raic, cl, tcl, usr, cupd, vsel;
   logic [7:0] mon;
   logic [7:0] rd;
   int fail_count = 0;
   int checks = 0;
   int n, m, i;

   e1lac_line_model i_line (.ref_clk(ref_clk), .txclk_run(txclk_run), .rx_zeros(rx_zeros),
      .transmit_clock_in(txc), .recovered_clock_in(rclk), .master_clock_in(mclk),
      .line_rx_pos(rxp), .line_rx_neg(rxn));
   e1lac_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transmit_clock_in(txc),
      .recovered_clock_in(rclk), .master_clock_in(mclk), .line_rx_pos(rxp), .line_rx_neg(rxn),
      .fmt_tx(fmt), .fmt_tx_nrz(nrz), .fmt_tx_frame_start(1'h0), .rx_status(st), .rx_ser_in(ser),
      .line_tx_pos(txp), .line_tx_neg(txn), .framer_rx(frx), .rx_clock_out(rxco), .rx_serial_out(rso),
      .tx_ais_force(ais), .tx_rai_force(rai), .rai_constant(raic), .carrier_loss(cl),
      .tx_clock_loss(tcl), .tx_clk_use_recovered(usr), .counter_update(cupd),
      .violation_count_select(vsel), .tx_channel_monitor_reg(mon));

   initial begin
      forever begin
         #5 ref_clk = ~ref_clk;
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic in_range(input int v, input int lo, input int hi);
      check({31'h0, (v >= lo && v <= hi)}, 32'h1);
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rdr(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      @(posedge ref_clk);
      #1 d = reg_rdata;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return tcl;
         1: return cl;
         2: return rai;
         3: return raic;
         default: return cupd;
      endcase
   endfunction
   // Counts two-cycle steps, optionally pulsing the frame tick, until the chosen flag is seen.
   task automatic run_until(input int s, input int bound, input logic tick, output int cnt);
      logic hit;
      hit = 1'h0;
      cnt = 0;
      while (!hit) begin
         if (cnt >= bound) begin
            fail_count++;
            $display("[ERR] %0t ns: wait ran out", $time);
            report_and_stop();
         end
         @(posedge ref_clk);
         st.frame_tick <= tick;
         #1 hit = (pick(s) === 1'h1);
         @(posedge ref_clk);
         st.frame_tick <= 1'h0;
         #1 hit = hit | (pick(s) === 1'h1);
         cnt++;
      end
   endtask
   task automatic rises(output int r);
      logic prev;
      prev = rxco;
      r = 0;
      repeat (96) begin
         @(posedge ref_clk);
         #1 if (rxco === 1'h1 && prev === 1'h0) r++;
         prev = rxco;
      end
   endtask

   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'h0;
      wr(8'h13, 8'ha5);
      rdr(8'h13, rd);
      check(rd, 8'ha5);
      wr(8'h15, 8'hff);
      rdr(8'h15, rd);
      check(rd, 8'h00);
      for (i = 0; i < 12; i++) begin
         wr(8'h12, rows[i].c1);
         wr(8'h13, rows[i].c2);
         wr(8'h14, rows[i].c3);
         fmt <= rows[i].fmt;
         st <= rows[i].st;
         ser <= rows[i].ser;
         rx_zeros <= rows[i].zer;
         settle(12);
         check({txp, txn}, rows[i].etx);
         if (rows[i].cfrx) check(frx, rows[i].efrx);
         check(rso, rows[i].eser);
         check({ais, rai}, rows[i].ealm);
         check(vsel, rows[i].evs);
         check(usr, rows[i].eusr);
      end
      wr(8'h12, 8'h80);
      rises(n);
      in_range(n, 23, 25);
      wr(8'h12, 8'h00);
      rises(n);
      in_range(n, 15, 17);
      wr(8'h13, 8'h04);
      txclk_run <= 1'h0;
      run_until(0, 200, 1'h0, n);
      in_range(n, 50, 56);
      settle(4);
      check(usr, 1'h1);
      wr(8'h13, 8'h00);
      settle(4);
      check({tcl, usr}, 2'h2);
      txclk_run <= 1'h1;
      settle(10);
      check(tcl, 1'h0);
      rx_zeros <= 1'h1;
      run_until(1, 2000, 1'h0, n);
      in_range(n, 755, 775);
      rx_zeros <= 1'h0;
      settle(14);
      check(cl, 1'h0);
      wr(8'h13, 8'h22);
      rx_zeros <= 1'h1;
      run_until(1, 7000, 1'h0, n);
      in_range(n, 6134, 6154);
      settle(4);
      check(ais, 1'h1);
      rx_zeros <= 1'h0;
      wr(8'h12, 8'h01);
      wr(8'h13, 8'h10);
      settle(14);
      check(rai, 1'h0);
      @(posedge ref_clk);
      st.fas_sync <= 1'h1;
      run_until(2, 1100, 1'h1, n);
      in_range(n, 1024, 1026);
      check(raic, 1'h0);
      run_until(3, 2300, 1'h1, m);
      in_range(n + m, 3199, 3203);
      @(posedge ref_clk);
      st.fas_sync <= 1'h0;
      wr(8'h13, 8'h80);
      run_until(4, 9000, 1'h1, n);
      run_until(4, 600, 1'h1, n);
      check(n, 500);
      wr(8'h13, 8'h00);
      run_until(4, 9000, 1'h1, n);
      run_until(4, 9000, 1'h1, n);
      check(n, 8000);
      // Data has been all zeros so far; a full transmit frame of ones must reach channel 0.
      check(mon, 8'h00);
      @(posedge ref_clk);
      nrz <= 1'h1;
      settle(1200);
      check(mon, 8'hff);
      wr(8'h14, 8'h20);
      settle(4);
      n = 0;
      m = 0;
      i = 0;
      repeat (100) begin
         @(posedge ref_clk);
         #1 if (txp === 1'h1) n++;
         if (txn === 1'h1) m++;
         if (txp === 1'h1 && txn === 1'h1) i++;
      end
      in_range(n, 15, 35);
      in_range(m, 15, 35);
      check(i, 0);
      // Reset lands while line all ones and a control bit are still active.
      @(posedge ref_clk);
      rst <= 1'h1;
      settle(3);
      check({txp, txn, frx, rxco, rso, ais, rai, raic, cl, tcl, usr, cupd, vsel, mon}, 23'h0);
      @(posedge ref_clk);
      rst <= 1'h0;
      for (i = 0; i < 4; i++) begin
         rdr(8'h12 + i[7:0], rd);
         check(rd, 8'h00);
      end
      report_and_stop();
   end
endmodule // tb_e1_loopback_alarm_clock_control
